// *** usart_pkg.sv ***
`default_nettype none
package usart_pkg;
  // Character and queue shape
  localparam int DATA_W = 9;
  localparam int WORD_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int FRAME_W = 13;
  localparam int NUM_INT = 10;
  // Data length codes
  localparam logic [1:0] LEN_7 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_9 = 2'h2;
  // Parity codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // Oversampling field holds clocks per bit minus one
  localparam logic [3:0] OSR_MIN = 4'h4;
  localparam logic [3:0] OSR_MAX = 4'hf;
  // Interrupt flag positions
  localparam int INT_RXRDY = 0;
  localparam int INT_TXRDY = 1;
  localparam int INT_RXIDLE = 2;
  localparam int INT_BRKCHG = 3;
  localparam int INT_FRAME = 4;
  localparam int INT_PARITY = 5;
  localparam int INT_OVERRUN = 6;
  localparam int INT_UNDERRUN = 7;
  localparam int INT_DCTS = 8;
  localparam int INT_NOISE = 9;
  // Reset values
  localparam logic [15:0] BRG_RST = 16'h0000;
  localparam logic [NUM_INT-1:0] FLAGS_RST = 10'h000;
  // Line rate ceilings and low rate clock
  localparam int CLK_HZ = 100_000_000;
  localparam int ASYNC_MAX_BPS = 10_000_000;
  localparam int SYNC_MAX_BPS = 25_000_000;
  localparam int LOWRATE_MAX_BAUD = 9600;
  localparam int LOWRATE_OSC_HZ = 32768;
  // Engine states
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic {RX_IDLE, RX_FRAME} rx_state_e;
endpackage
`default_nettype wire

// *** usart_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module usart_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wptr_r; // Write index
  logic [AW-1:0] rptr_r; // Read index
  logic [AW:0] cnt_r; // Fill level
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = i_valid && o_ready;
  assign pop = i_ready && o_valid;
  assign o_data = mem[rptr_r];

  // Level bookkeeping
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Flags registered from the next level so both sides see flops
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_ready <= cnt_nxt != FULL;
      o_valid <= cnt_nxt != '0;
    end
  end

  // Pointers wrap naturally, depth is a power of two
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

  // Memory has no reset, contents are don't care until written
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wptr_r] <= i_data;
    end
  end
endmodule // usart_fifo
`default_nettype wire

// *** usart_port.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// - Seven, eight or nine data, 1-2 stops
// - Odd, even or no parity
// - Oversampling five to sixteen clocks per bit
// - Three sample vote, noise flag on disagreement
// - Sixteen entry queue each direction
// - Sync master/slave, sample phase, continuous clock
// - Nine bit address marking, software compares
// - RS-485 enable around own transmissions
// - Autobaud measures start bit, sets divider
// - CTS holds transmit, RTS when full
// - Report CTS changes, transmit disable bit
// - Optional status packed with received data
// - Break send, detect, report changes
// - Ten maskable interrupt sources
// - Loopback of data and flow control
// - Baud from shared fractional divider tick
// - Low rate oscillator mode, wake on character
// - Up to 10M async, 25M sync
// - DMA requests for both queues
// - Sync slave uses external clock, wakes
module usart_port (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_func_sel,
  input wire logic [1:0] i_data_len,
  input wire logic i_two_stop,
  input wire logic [1:0] i_parity,
  input wire logic [3:0] i_osr,
  input wire logic [15:0] i_brg_div,
  input wire logic i_baud_tick,
  input wire logic i_lowrate_en,
  input wire logic i_rtc_tick,
  input wire logic i_autobaud_en,
  input wire logic i_sync_en,
  input wire logic i_sync_master,
  input wire logic i_sample_rise,
  input wire logic i_cont_clock,
  input wire logic i_loopback,
  input wire logic i_flow_en,
  input wire logic i_tx_disable,
  input wire logic i_break_tx,
  input wire logic i_rs485_en,
  input wire logic i_stat_in_data,
  input wire logic [usart_pkg::NUM_INT-1:0] i_int_en,
  input wire logic [usart_pkg::NUM_INT-1:0] i_int_clr,
  input wire logic [usart_pkg::DATA_W-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [usart_pkg::WORD_W-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic o_tx_dma_req,
  output logic o_rx_dma_req,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_cts_n,
  output logic o_rts_n,
  input wire logic i_sclk,
  output logic o_sclk,
  output logic o_sclk_oe_n,
  output logic o_rs485_oe,
  output logic [usart_pkg::NUM_INT-1:0] o_int_flags,
  output logic o_irq,
  output logic o_rx_break,
  output logic o_autobaud_done,
  output logic [15:0] o_brg_value,
  output logic o_wake
);
  import usart_pkg::*;

  // Pin synchronisers, first stage read only by second
  logic rxd_m, rxd_s, cts_m, cts_s, sclk_m, sclk_s, sclk_d;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      {rxd_m, rxd_s, cts_m, cts_s} <= 4'hf;
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
    end else begin
      {rxd_m, rxd_s} <= {i_rxd, rxd_m};
      {cts_m, cts_s} <= {i_cts_n, cts_m};
      {sclk_m, sclk_s, sclk_d} <= {i_sclk, sclk_m, sclk_s};
    end
  end

  // Shared format decode
  logic [3:0] osr; // Clocks per bit minus one
  logic [3:0] mid; // Centre sample index
  logic [3:0] nbits; // Data bits
  logic par_en;
  logic [3:0] total; // Whole frame length in bits
  assign osr = (i_osr < OSR_MIN) ? OSR_MIN : i_osr;
  assign mid = osr >> 1;
  assign nbits = (i_data_len == LEN_7) ? 4'h7 :
                 (i_data_len == LEN_9) ? 4'h9 : 4'h8;
  assign par_en = i_parity != PAR_NONE;
  assign total = 4'h2 + nbits + {3'h0, par_en} + {3'h0, i_two_stop};

  // Baud prescaler on the shared divider tick or low rate tick
  logic [15:0] brg_cnt_r;
  logic [15:0] brg_r;
  logic src;
  logic smp_tick; // One pulse per sample period
  assign src = i_lowrate_en ? i_rtc_tick : i_baud_tick;
  assign smp_tick = src && (brg_cnt_r >= brg_r);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      brg_cnt_r <= BRG_RST;
    end else if (!i_func_sel || smp_tick) begin
      brg_cnt_r <= BRG_RST;
    end else if (src) begin
      brg_cnt_r <= brg_cnt_r + 16'h0001;
    end
  end

  // Autobaud: count groups of osr+1 source ticks across a start bit
  logic [15:0] ab_cnt_r;
  logic [3:0] ab_sub_r;
  logic ab_run_r;
  logic rx_line, rx_d;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ab_run_r <= 1'b0;
      ab_cnt_r <= '0;
      ab_sub_r <= '0;
      o_autobaud_done <= 1'b0;
      o_brg_value <= BRG_RST;
    end else if (!i_autobaud_en) begin
      ab_run_r <= 1'b0;
      o_autobaud_done <= 1'b0;
    end else if (!o_autobaud_done) begin
      if (!ab_run_r && rx_d && !rx_line) begin
        ab_run_r <= 1'b1; // Falling edge of start bit
        ab_cnt_r <= '0;
        ab_sub_r <= '0;
      end else if (ab_run_r && rx_line) begin
        ab_run_r <= 1'b0; // Start bit over, program divider
        o_autobaud_done <= ab_cnt_r != '0;
        o_brg_value <= ab_cnt_r - 16'h0001;
      end else if (ab_run_r && src) begin
        ab_sub_r <= (ab_sub_r == osr) ? 4'h0 : ab_sub_r + 4'h1;
        if (ab_sub_r == osr) begin
          ab_cnt_r <= ab_cnt_r + 16'h0001;
        end
      end
    end
  end
  assign brg_r = o_autobaud_done ? o_brg_value : i_brg_div;

  // Synchronous clock: master divides, slave follows pin
  logic tx_busy;
  logic tog, rise_e, fall_e, samp_e, shift_e, sync_slave;
  assign sync_slave = i_sync_en && !i_sync_master;
  assign tog = i_sync_en && i_sync_master && smp_tick &&
               (tx_busy || i_cont_clock);
  assign rise_e = sync_slave ? (sclk_s && !sclk_d) : (tog && !o_sclk);
  assign fall_e = sync_slave ? (!sclk_s && sclk_d) : (tog && o_sclk);
  assign samp_e = i_sample_rise ? rise_e : fall_e;
  assign shift_e = i_sample_rise ? fall_e : rise_e;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sclk <= 1'b0;
      o_sclk_oe_n <= 1'b1;
    end else begin
      o_sclk_oe_n <= !(i_sync_en && i_sync_master);
      if (!i_sync_en) begin
        o_sclk <= 1'b0;
      end else if (tog) begin
        o_sclk <= !o_sclk;
      end
    end
  end

  // Queues: transmit from software or DMA, receive to it
  logic [DATA_W-1:0] txf_data;
  logic txf_vld, tx_go;
  logic [WORD_W-1:0] rx_word_r;
  logic rx_push_r, rxf_rdy;
  usart_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .i_clock(i_clock), .i_rstn(i_rstn),
    .i_data(i_tx_data), .i_valid(i_tx_valid), .o_ready(o_tx_ready),
    .o_data(txf_data), .o_valid(txf_vld), .i_ready(tx_go));
  usart_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rxq (
    .i_clock(i_clock), .i_rstn(i_rstn),
    .i_data(rx_word_r), .i_valid(rx_push_r), .o_ready(rxf_rdy),
    .o_data(o_rx_data), .o_valid(o_rx_valid), .i_ready(i_rx_ready));

  // Flow control and loopback steering
  logic cts_in, cts_q, cts_block;
  assign cts_in = i_loopback ? o_rts_n : cts_s;
  assign cts_block = i_flow_en && cts_in;
  assign rx_line = i_loopback ? o_txd : rxd_s;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rts_n <= 1'b1;
      cts_q <= 1'b1;
      rx_d <= 1'b1;
    end else begin
      o_rts_n <= i_flow_en ? !rxf_rdy : 1'b0;
      cts_q <= cts_in;
      rx_d <= rx_line;
    end
  end

  // Transmit frame build: start, data LSB first, parity, stops
  tx_state_e tx_st;
  logic [FRAME_W-1:0] tx_sh, tx_frame;
  logic [DATA_W-1:0] tx_dm;
  logic [3:0] tx_left, tx_smp;
  logic [2:0] tx_tail;
  logic tx_pbit, tx_done;
  assign tx_busy = tx_st == TX_SHIFT;
  assign tx_dm = txf_data & ~(9'h1ff << nbits);
  assign tx_pbit = (i_parity == PAR_ODD) ? ~^tx_dm : ^tx_dm;
  assign tx_tail = par_en ? {2'h3, tx_pbit} : 3'h7;
  assign tx_frame = (FRAME_W'(tx_tail) << (nbits + 4'h1)) |
                    (FRAME_W'(tx_dm) << 1);
  assign tx_go = (tx_st == TX_IDLE) && txf_vld && i_func_sel &&
                 !i_tx_disable && !cts_block && !i_break_tx &&
                 (!sync_slave || shift_e);
  assign tx_done = i_sync_en ? shift_e : (smp_tick && tx_smp == osr);

  // Transmit engine
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_st <= TX_IDLE;
      tx_sh <= '1;
      tx_left <= '0;
      tx_smp <= '0;
      o_txd <= 1'b1;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          tx_smp <= '0;
          if (tx_go) begin
            tx_sh <= tx_frame;
            tx_left <= total - 4'h1;
            tx_st <= TX_SHIFT;
            o_txd <= 1'b0;
          end else begin
            o_txd <= !i_break_tx;
          end
        end
        TX_SHIFT: begin
          if (smp_tick) begin
            tx_smp <= (tx_smp == osr) ? 4'h0 : tx_smp + 4'h1;
          end
          if (tx_done) begin
            tx_smp <= '0;
            if (tx_left == '0) begin
              tx_st <= TX_IDLE;
              o_txd <= 1'b1;
            end else begin
              tx_sh <= {1'b1, tx_sh[FRAME_W-1:1]};
              o_txd <= tx_sh[1];
              tx_left <= tx_left - 4'h1;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Transceiver direction enable follows own frames only
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rs485_oe <= 1'b0;
    end else begin
      o_rs485_oe <= i_rs485_en && (tx_busy || tx_go);
    end
  end

  // Receive bit strobe: vote in async, one sample in sync
  rx_state_e rx_st;
  logic [3:0] rx_smp, rx_left;
  logic [1:0] vote_r;
  logic bit_stb, bit_val, bit_noise;
  assign bit_stb = (rx_st == RX_FRAME) &&
                   (i_sync_en ? samp_e : (smp_tick && rx_smp == mid + 4'h1));
  assign bit_val = i_sync_en ? rx_line :
                   ((vote_r[0] & vote_r[1]) | (vote_r[0] & rx_line) |
                    (vote_r[1] & rx_line));
  assign bit_noise = !i_sync_en &&
                     !(vote_r[0] == vote_r[1] && vote_r[1] == rx_line);

  // Frame decode at the last bit
  logic [FRAME_W-1:0] rx_sh, rx_al;
  logic [DATA_W-1:0] rx_dat;
  logic rx_pbit, rx_stop, rx_pe, rx_brk, rx_noise_r, rx_last;
  assign rx_al = {bit_val, rx_sh[FRAME_W-1:1]} >> (4'hd - total);
  assign rx_dat = rx_al[DATA_W:1] & ~(9'h1ff << nbits);
  assign rx_pbit = rx_al[nbits + 4'h1];
  assign rx_stop = rx_al[nbits + 4'h1 + {3'h0, par_en}];
  assign rx_pe = par_en && (rx_pbit != ((i_parity == PAR_ODD) ?
                 ~^rx_dat : ^rx_dat));
  assign rx_brk = (rx_dat == '0) && !rx_stop &&
                  !(par_en && rx_pbit);
  assign rx_last = bit_stb && rx_left == '0;

  // Receive engine
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_st <= RX_IDLE;
      rx_smp <= '0;
      rx_left <= '0;
      vote_r <= 2'h3;
      rx_sh <= '0;
      rx_noise_r <= 1'b0;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          rx_smp <= '0;
          rx_noise_r <= 1'b0;
          if (i_func_sel && !i_sync_en && rx_d && !rx_line) begin
            rx_st <= RX_FRAME;
            rx_left <= total - 4'h1;
          end else if (i_func_sel && i_sync_en && samp_e && !rx_line)
          begin
            rx_st <= RX_FRAME;
            rx_left <= total - 4'h2;
            rx_sh <= {1'b0, rx_sh[FRAME_W-1:1]};
          end
        end
        RX_FRAME: begin
          if (smp_tick) begin
            rx_smp <= (rx_smp == osr) ? 4'h0 : rx_smp + 4'h1;
            vote_r <= {vote_r[0], rx_line};
          end
          if (bit_stb) begin
            rx_sh <= {bit_val, rx_sh[FRAME_W-1:1]};
            rx_noise_r <= rx_noise_r | bit_noise;
            rx_left <= rx_left - 4'h1;
            if (rx_last || (!i_sync_en && rx_left == total - 4'h1 &&
                            bit_val)) begin
              rx_st <= RX_IDLE; // End of frame or false start
            end
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Queue write, break state and wake
  logic ovr_ev, brk_chg, idle_ev;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_push_r <= 1'b0;
      rx_word_r <= '0;
      o_rx_break <= 1'b0;
      o_wake <= 1'b0;
      ovr_ev <= 1'b0;
      idle_ev <= 1'b0;
    end else begin
      rx_push_r <= rx_last && !rx_brk && rxf_rdy;
      ovr_ev <= rx_last && !rx_brk && !rxf_rdy; // Character lost
      idle_ev <= rx_last;
      o_wake <= rx_last && !rx_brk &&
                (i_lowrate_en || sync_slave);
      if (rx_last) begin
        rx_word_r <= i_stat_in_data ?
                     {rx_noise_r | bit_noise, !rx_stop, rx_pe, rx_dat} :
                     {3'h0, rx_dat};
      end
      if (rx_last && rx_brk) begin
        o_rx_break <= 1'b1;
      end else if (o_rx_break && rx_line) begin
        o_rx_break <= 1'b0;
      end
    end
  end
  assign brk_chg = (rx_last && rx_brk && !o_rx_break) ||
                   (o_rx_break && rx_line);

  // Sticky event flags, a new event wins over its clear
  logic [NUM_INT-1:0] ev, flags_nxt;
  always_comb begin
    ev = '0;
    ev[INT_RXRDY] = o_rx_valid;
    ev[INT_TXRDY] = o_tx_ready;
    ev[INT_RXIDLE] = idle_ev;
    ev[INT_BRKCHG] = brk_chg;
    ev[INT_FRAME] = rx_last && !rx_stop && !rx_brk;
    ev[INT_PARITY] = rx_last && rx_pe && !rx_brk;
    ev[INT_OVERRUN] = ovr_ev;
    ev[INT_UNDERRUN] = sync_slave && !tx_busy && shift_e && !txf_vld;
    ev[INT_DCTS] = cts_q != cts_in;
    ev[INT_NOISE] = bit_stb && bit_noise;
    flags_nxt = (o_int_flags & ~i_int_clr) | ev;
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_int_flags <= FLAGS_RST;
      o_irq <= 1'b0;
      o_tx_dma_req <= 1'b0;
      o_rx_dma_req <= 1'b0;
    end else begin
      o_int_flags <= flags_nxt;
      o_irq <= |(flags_nxt & i_int_en);
      o_tx_dma_req <= o_tx_ready;
      o_rx_dma_req <= o_rx_valid;
    end
  end

  // Checks
  idle_line_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (tx_st == TX_IDLE && !tx_go && !i_break_tx) |=> o_txd)
    else $error("line not high while idle");
  break_tx_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (tx_st == TX_IDLE && i_break_tx) |=> !o_txd)
    else $error("break not driven");
  cts_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (tx_st == TX_IDLE && cts_block) |=> tx_st == TX_IDLE)
    else $error("sent while clear to send deasserted");
  tx_disable_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (tx_st == TX_IDLE && i_tx_disable) |=> !o_rs485_oe)
    else $error("transmit started while disabled");
  rts_full_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_flow_en && !rxf_rdy) |=> o_rts_n)
    else $error("request to send held while full");
  dir_enable_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_rs485_en && tx_busy) |=> o_rs485_oe)
    else $error("direction enable low during frame");
  noise_flag_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (bit_stb && bit_noise) |=> o_int_flags[INT_NOISE])
    else $error("noise not flagged");
  irq_gate_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_irq |-> $past(|(flags_nxt & i_int_en))))
    else $error("interrupt without enabled flag");
  loop_path_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_loopback |-> (rx_line == o_txd && cts_in == o_rts_n))
    else $error("loopback path broken");
endmodule // usart_port
`default_nettype wire

// *** remote_serial.sv ***
`timescale 1ns/100ps
`default_nettype none
// Remote serial device: samples our transmit line, sends frames back
module remote_serial #(
  parameter int BIT = 5
) (
  input wire logic i_clock,
  input wire logic i_line,
  input wire logic [3:0] i_bits,
  output logic o_line,
  output logic o_cts_n
);
  logic [10:0] last_r; // Last frame seen, stop bits above the data
  int count_r; // Frames seen so far
  initial begin
    o_line = 1'b1; // Line idles high
    o_cts_n = 1'b0;
    last_r = '0;
    count_r = 0;
  end
  // Mid-bit sampling; a dip shorter than half a bit is no start
  always begin
    @(negedge i_line);
    repeat (BIT / 2) @(posedge i_clock);
    if (i_line == 1'b0) begin
      last_r = '0;
      for (int i = 0; i <= int'(i_bits); i++) begin
        repeat (BIT) @(posedge i_clock);
        last_r[i] = i_line; // LSB first, stops last
      end
      count_r++;
    end
  end
  // Start low, n bits LSB first, stop high; changes at falling edge
  task automatic send(input logic [9:0] v, input int n);
    @(negedge i_clock);
    o_line = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(negedge i_clock);
      o_line = v[i];
    end
    repeat (BIT) @(negedge i_clock);
    o_line = 1'b1;
    repeat (BIT * 2) @(negedge i_clock);
  endtask
  // Clear-to-send is ours to drive, active low
  task automatic set_cts(input logic v);
    @(negedge i_clock);
    o_cts_n = v;
  endtask
endmodule // remote_serial
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
  import usart_pkg::*;
  logic i_clock, i_rstn, i_func_sel, i_two_stop, i_baud_tick, i_lowrate_en;
  logic i_rtc_tick, i_autobaud_en, i_sync_en, i_sync_master, i_sample_rise;
  logic i_cont_clock, i_loopback, i_flow_en, i_tx_disable, i_break_tx;
  logic i_rs485_en, i_stat_in_data, i_tx_valid, i_rx_ready, i_sclk;
  logic [1:0] i_data_len, i_parity;
  logic [3:0] i_osr, rx_bits;
  logic [15:0] i_brg_div;
  logic [NUM_INT-1:0] i_int_en, i_int_clr, o_int_flags;
  logic [DATA_W-1:0] i_tx_data;
  logic [WORD_W-1:0] o_rx_data;
  logic o_tx_ready, o_rx_valid, o_tx_dma_req, o_rx_dma_req, o_txd, o_rts_n;
  logic o_rs485_oe, o_irq, i_rxd, i_cts_n, o_rx_break;
  int miscompares = 0; // Mismatches seen
  int checks = 0; // Comparisons made
  int base; // Frame count before a scenario
  usart_port dut_u (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_func_sel(i_func_sel), .i_data_len(i_data_len), .i_two_stop(i_two_stop),
    .i_parity(i_parity), .i_osr(i_osr), .i_brg_div(i_brg_div),
    .i_baud_tick(i_baud_tick), .i_lowrate_en(i_lowrate_en),
    .i_rtc_tick(i_rtc_tick), .i_autobaud_en(i_autobaud_en),
    .i_sync_en(i_sync_en), .i_sync_master(i_sync_master),
    .i_sample_rise(i_sample_rise), .i_cont_clock(i_cont_clock),
    .i_loopback(i_loopback), .i_flow_en(i_flow_en),
    .i_tx_disable(i_tx_disable), .i_break_tx(i_break_tx),
    .i_rs485_en(i_rs485_en), .i_stat_in_data(i_stat_in_data),
    .i_int_en(i_int_en), .i_int_clr(i_int_clr), .i_tx_data(i_tx_data),
    .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data),
    .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .o_tx_dma_req(o_tx_dma_req), .o_rx_dma_req(o_rx_dma_req), .i_rxd(i_rxd),
    .o_txd(o_txd), .i_cts_n(i_cts_n), .o_rts_n(o_rts_n), .i_sclk(i_sclk),
    .o_sclk(), .o_sclk_oe_n(), .o_rs485_oe(o_rs485_oe),
    .o_int_flags(o_int_flags), .o_irq(o_irq), .o_rx_break(o_rx_break),
    .o_autobaud_done(), .o_brg_value(), .o_wake());
  // Five clocks a bit: tick every cycle, divider zero, osr 4
  remote_serial #(.BIT(5)) remote_u (.i_clock(i_clock), .i_line(o_txd),
    .i_bits(rx_bits), .o_line(i_rxd), .o_cts_n(i_cts_n));
  // Verdict in one place; a pass needs at least one comparison
  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Queue a character once the transmit queue has room
  task automatic tx_put(input logic [DATA_W-1:0] d);
    @(negedge i_clock);
    for (int n = 0; n < 100 && o_tx_ready !== 1'b1; n++) @(negedge i_clock);
    if (o_tx_ready !== 1'b1) miscompares++;
    i_tx_data = d;
    i_tx_valid = 1'b1;
    @(negedge i_clock);
    i_tx_valid = 1'b0;
  endtask
  // Compare the queue head, then pop it for one edge
  task automatic rx_pop(input logic [WORD_W-1:0] e);
    @(negedge i_clock);
    for (int n = 0; n < 2000 && o_rx_valid !== 1'b1; n++) @(negedge i_clock);
    if (o_rx_valid !== 1'b1) miscompares++;
    `CHECK(o_rx_data, e)
    i_rx_ready = 1'b1;
    @(negedge i_clock);
    i_rx_ready = 1'b0;
  endtask
  // Bounded wait for the remote side to have seen c frames
  task automatic wait_frames(input int c);
    for (int n = 0; n < 3000 && remote_u.count_r < c; n++) @(negedge i_clock);
    if (remote_u.count_r < c) miscompares++;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Watchdog: the scenarios need well under a tenth of this
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {i_rstn, i_two_stop, i_lowrate_en, i_rtc_tick, i_autobaud_en} = '0;
    {i_sync_en, i_sync_master, i_sample_rise, i_cont_clock} = '0;
    {i_loopback, i_flow_en, i_tx_disable, i_break_tx, i_sclk} = '0;
    {i_stat_in_data, i_tx_valid, i_rx_ready} = '0;
    {i_func_sel, i_baud_tick, i_rs485_en} = 3'h7;
    i_data_len = LEN_8;
    i_parity = PAR_NONE;
    i_osr = OSR_MIN;
    i_brg_div = 16'h0000;
    i_int_en = '1;
    i_int_clr = '0;
    i_tx_data = '0;
    rx_bits = 4'h8;
    repeat (5) @(negedge i_clock);
    `CHECK({o_txd, o_tx_ready, o_int_flags}, {2'h2, FLAGS_RST})
    i_rstn = 1'b1;
    repeat (2) @(negedge i_clock);
    // Plain 8N1 frame, direction enable around it
    tx_put(9'h0a5);
    repeat (4) @(negedge i_clock);
    `CHECK(o_rs485_oe, 1'b1)
    wait_frames(1);
    `CHECK(remote_u.last_r[8:0], 9'h1a5)
    repeat (6) @(negedge i_clock);
    `CHECK(o_rs485_oe, 1'b0)
    // Seven bits, both parities, two stops
    i_data_len = LEN_7;
    i_two_stop = 1'b1;
    rx_bits = 4'h9;
    for (int k = 0; k < 2; k++) begin
      i_parity = (k == 0) ? PAR_EVEN : PAR_ODD;
      tx_put(9'h015);
      wait_frames(k + 2);
      `CHECK(remote_u.last_r[9:0], (k == 0) ? 10'h395 : 10'h315)
    end
    {i_data_len, i_parity, i_two_stop, rx_bits} = {LEN_8, PAR_NONE, 5'h08};
    // Receive, then a parity error with status packed in
    remote_u.send(10'h03c, 8);
    rx_pop(12'h03c);
    i_parity = PAR_EVEN;
    i_stat_in_data = 1'b1;
    i_int_en = '0;
    i_int_en[INT_PARITY] = 1'b1;
    remote_u.send(10'h103, 9);
    rx_pop(12'h203);
    `CHECK({o_int_flags[INT_PARITY], o_irq}, 2'h3)
    i_int_clr = '1;
    @(negedge i_clock);
    i_int_clr = '0;
    @(negedge i_clock);
    `CHECK({o_int_flags[INT_PARITY], o_irq}, 2'h0)
    {i_parity, i_stat_in_data} = {PAR_NONE, 1'b0};
    // Stop bit sent low
    remote_u.send(10'h07e, 9);
    rx_pop(12'h07e);
    `CHECK(o_int_flags[INT_FRAME], 1'b1)
    // Break: zero data and a low stop, never queued
    remote_u.send(10'h000, 9);
    `CHECK({o_int_flags[INT_BRKCHG], o_rx_break, o_rx_valid}, 3'h4)
    // Seventeen characters into a sixteen entry queue
    for (int i = 0; i < 17; i++) remote_u.send(10'h040 + 10'(i), 8);
    `CHECK({o_int_flags[INT_OVERRUN], o_rx_dma_req}, 2'h3)
    for (int i = 0; i < 16; i++) rx_pop(12'h040 + 12'(i));
    repeat (2) @(negedge i_clock);
    `CHECK(o_rx_valid, 1'b0)
    // Fill the transmit queue while transmission is suspended
    i_tx_disable = 1'b1;
    base = remote_u.count_r;
    for (int i = 0; i < 16; i++) tx_put(9'h020 + 9'(i));
    @(negedge i_clock);
    `CHECK({o_tx_ready, o_tx_dma_req}, 2'h0)
    repeat (40) @(negedge i_clock);
    `CHECK(remote_u.count_r, base)
    i_tx_disable = 1'b0;
    wait_frames(base + 16);
    `CHECK(remote_u.last_r[8:0], 9'h12f)
    // Clear-to-send held off, then granted
    i_flow_en = 1'b1;
    remote_u.set_cts(1'b1);
    repeat (4) @(negedge i_clock);
    `CHECK({o_int_flags[INT_DCTS], o_rts_n}, 2'h2)
    base = remote_u.count_r;
    tx_put(9'h05a);
    repeat (60) @(negedge i_clock);
    `CHECK({remote_u.count_r == base, o_txd}, 2'h3)
    remote_u.set_cts(1'b0);
    wait_frames(base + 1);
    `CHECK(remote_u.last_r[8:0], 9'h15a)
    i_flow_en = 1'b0;
    // Loopback returns our own character
    i_loopback = 1'b1;
    tx_put(9'h081);
    rx_pop(12'h081);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
